//--- scmc_ctrl.sv
// Mode, clock and bus control registers of a multi-mode serial channel
//
// Overview of operation
// - Reset clears the mode register to zero, and it takes bit and byte writes.
// - Mode bit 7 stops the channel at 0 and enables it at 1.
// - Mode bit 6 reads 1 when slave address equals shift register data, else 0.
// - The address match flag is held at 0 while the channel is disabled.
// - With wake-up on in I2C mode, only an address match after a start raises one.
// - Mode bits 4:3 pick 3-wire or 2-wire/I2C; bit 2 picks bit order or data pin pair.
// - Clock select 0x takes the pin clock, 10 the timer two output, 11 the prescaler.
// - In I2C mode the timer two clock runs at one sixteenth of the timer output.
// - In 3-wire transmit-only use the serial input pin is released as a port pin.
// - Reset clears the bus interface control register; it takes bit and byte writes.
// - Start detected flag sets on a start, clears on transfer start, stop, disable, reset.
`timescale 1ns/1ps
`default_nettype none
module scmc_ctrl
    import scmc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [15:0] mem_addr,
    input wire logic mem_byte_wr,
    input wire logic mem_bit_wr,
    input wire logic [2:0] mem_bit_idx,
    input wire logic mem_bit_val,
    input wire logic [7:0] mem_wdata,
    input wire logic mem_rd,
    output logic [7:0] mem_rdata,
    input wire logic [7:0] shift_register,
    input wire logic [7:0] slave_addr,
    input wire logic i2c_protocol,
    input wire logic transmit_only,
    input wire logic transfer_start,
    input wire logic transfer_done,
    input wire logic start_cond_det,
    input wire logic stop_cond_det,
    input wire logic addr_received,
    input wire logic ack_det,
    input wire logic serial_clock_pin,
    input wire logic timer_two_output,
    input wire logic prescaler_tick,
    output logic channel_enable,
    output logic three_wire_mode,
    output logic two_wire_mode,
    output logic i2c_mode,
    output logic pin_or_order_select,
    output logic wakeup_enable,
    output logic serial_in_released,
    output logic serial_clk_tick,
    output logic [7:0] prescaler_select,
    output logic open_drain_busy,
    output logic ack_auto_enable,
    output logic ack_trigger,
    output logic start_trigger,
    output logic release_trigger,
    output logic address_match_flag,
    output logic start_detected_flag,
    output logic interrupt_req
);
    // Register state
    logic [7:0] mode_r, mode_nxt;
    logic [7:0] busctl_r, busctl_nxt;
    logic [7:0] presc_r, presc_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic match_r, match_nxt;
    logic startd_r, startd_nxt;
    logic ackd_r, ackd_nxt;
    logic stopd_r, stopd_nxt;
    logic irq_r, irq_nxt;
    logic [2:0] trig_r, trig_nxt;
    // Clock path state
    logic pin_d_r, pin_d_nxt;
    logic tmr_d_r, tmr_d_nxt;
    logic tick_r, tick_nxt;
    scmc_src_t src_r, src_nxt;
    logic tmr_edge, tmr_div16;

    // Decoded write strobes and data
    logic wr_mode, wr_busctl, wr_presc;
    logic [7:0] wval_mode, wval_busctl;
    logic en, in_i2c, two_wire;

    assign wr_mode = (mem_byte_wr || mem_bit_wr) && (mem_addr == SCMC_ADDR_MODE);
    assign wr_busctl = (mem_byte_wr || mem_bit_wr) && (mem_addr == SCMC_ADDR_BUSCTL);
    // Prescaler select is byte wide only
    assign wr_presc = mem_byte_wr && (mem_addr == SCMC_ADDR_PRESC);
    assign en = mode_r[SCMC_M_EN];
    assign two_wire = mode_r[SCMC_M_MODE_HI] && mode_r[SCMC_M_MODE_MID];
    assign in_i2c = two_wire && i2c_protocol;

    // Bit writes merge one bit into the current value
    always_comb begin
        wval_mode = mode_r;
        wval_busctl = busctl_r;
        if (mem_bit_wr) begin
            wval_mode[mem_bit_idx] = mem_bit_val;
            wval_busctl[mem_bit_idx] = mem_bit_val;
        end else begin
            wval_mode = mem_wdata;
            wval_busctl = mem_wdata;
        end
    end

    // Timer output divided by sixteen for I2C use
    assign tmr_edge = timer_two_output && !tmr_d_r;
    scmc_pulse_div #(
        .DIV(SCMC_I2C_TIMER_DIV)
    ) u_tmr_div (
        .clk(clk),
        .rst_n(rst_n),
        .clr(src_r != SCMC_SRC_TIMER),
        .pulse_in(tmr_edge),
        .pulse_out(tmr_div16)
    );

    // Register file, flags, interrupt and clock selection
    always_comb begin
        mode_nxt = mode_r;
        busctl_nxt = busctl_r;
        presc_nxt = presc_r;
        rdata_nxt = rdata_r;
        trig_nxt = 3'h0;
        irq_nxt = 1'b0;
        pin_d_nxt = serial_clock_pin;
        tmr_d_nxt = timer_two_output;
        tick_nxt = 1'b0;
        // Match flag is hardware only; software writes cannot reach it
        if (wr_mode) begin
            mode_nxt = (wval_mode & SCMC_MODE_WMASK) | (mode_r & ~SCMC_MODE_WMASK);
        end
        if (wr_busctl) begin
            busctl_nxt = (wval_busctl & SCMC_BUSCTL_WMASK)
                | (busctl_r & ~SCMC_BUSCTL_WMASK);
            // Trigger bits act once and always read back as zero
            trig_nxt[2] = wval_busctl[SCMC_B_ACKT];
            trig_nxt[1] = wval_busctl[SCMC_B_CMDT];
            trig_nxt[0] = wval_busctl[SCMC_B_RELT];
        end
        if (wr_presc) begin
            presc_nxt = mem_wdata;
        end
        // Comparator result, forced low while stopped
        match_nxt = en && (slave_addr == shift_register);
        // Start flag: set beats the transfer and stop clears, disable forces low
        startd_nxt = startd_r;
        if (transfer_start || stop_cond_det) begin
            startd_nxt = 1'b0;
        end
        if (start_cond_det) begin
            startd_nxt = 1'b1;
        end
        ackd_nxt = ackd_r;
        if (transfer_start) begin
            ackd_nxt = 1'b0;
        end
        if (ack_det) begin
            ackd_nxt = 1'b1;
        end
        stopd_nxt = stopd_r;
        if (transfer_start || (addr_received && !match_r)) begin
            stopd_nxt = 1'b0;
        end
        if (stop_cond_det) begin
            stopd_nxt = 1'b1;
        end
        if (!en) begin
            startd_nxt = 1'b0;
            ackd_nxt = 1'b0;
            stopd_nxt = 1'b0;
            trig_nxt = 3'h0;
        end
        // Interrupt source depends on the wake-up bit
        if (en) begin
            if (!mode_r[SCMC_M_WAKE]) begin
                irq_nxt = transfer_done;
            end else begin
                irq_nxt = in_i2c && addr_received && startd_r && match_r;
            end
        end
        // Clock source; a change of source restarts the divider
        if (mode_r[SCMC_M_CLK_HI:SCMC_M_CLK_LO] == SCMC_CLK_PRESC) begin
            src_nxt = SCMC_SRC_PRESC;
        end else if (mode_r[SCMC_M_CLK_HI:SCMC_M_CLK_LO] == SCMC_CLK_TIMER) begin
            src_nxt = SCMC_SRC_TIMER;
        end else begin
            src_nxt = SCMC_SRC_EXT;
        end
        case (src_r)
            SCMC_SRC_EXT: tick_nxt = serial_clock_pin && !pin_d_r;
            SCMC_SRC_TIMER: tick_nxt = in_i2c ? tmr_div16 : tmr_edge;
            SCMC_SRC_PRESC: tick_nxt = prescaler_tick;
            default: tick_nxt = 1'b0;
        endcase
        if (!en) begin
            tick_nxt = 1'b0;
        end
        // Read data registered; unmapped addresses read zero
        if (mem_rd) begin
            case (mem_addr)
                SCMC_ADDR_MODE: begin
                    rdata_nxt = mode_r;
                    rdata_nxt[SCMC_M_MATCH] = match_r;
                end
                SCMC_ADDR_BUSCTL: begin
                    rdata_nxt = busctl_r;
                    rdata_nxt[SCMC_B_ACKD] = ackd_r;
                    rdata_nxt[SCMC_B_START] = startd_r;
                    rdata_nxt[SCMC_B_STOPD] = stopd_r;
                end
                SCMC_ADDR_PRESC: rdata_nxt = presc_r;
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_r <= SCMC_RST_MODE;
            busctl_r <= SCMC_RST_BUSCTL;
            presc_r <= SCMC_RST_PRESC;
            rdata_r <= 8'h00;
            match_r <= 1'b0;
            startd_r <= 1'b0;
            ackd_r <= 1'b0;
            stopd_r <= 1'b0;
            irq_r <= 1'b0;
            trig_r <= 3'h0;
            pin_d_r <= 1'b0;
            tmr_d_r <= 1'b0;
            tick_r <= 1'b0;
            src_r <= SCMC_SRC_EXT;
        end else begin
            mode_r <= mode_nxt;
            busctl_r <= busctl_nxt;
            presc_r <= presc_nxt;
            rdata_r <= rdata_nxt;
            match_r <= match_nxt;
            startd_r <= startd_nxt;
            ackd_r <= ackd_nxt;
            stopd_r <= stopd_nxt;
            irq_r <= irq_nxt;
            trig_r <= trig_nxt;
            pin_d_r <= pin_d_nxt;
            tmr_d_r <= tmr_d_nxt;
            tick_r <= tick_nxt;
            src_r <= src_nxt;
        end
    end

    // Decoded control outputs, registered one cycle behind the register
    logic [7:0] ctl_r, ctl_nxt;
    always_comb begin
        ctl_nxt[0] = en;
        ctl_nxt[1] = !mode_r[SCMC_M_MODE_HI];
        ctl_nxt[2] = two_wire && !i2c_protocol;
        ctl_nxt[3] = in_i2c;
        ctl_nxt[4] = mode_r[SCMC_M_PIN];
        ctl_nxt[5] = mode_r[SCMC_M_WAKE];
        // Input pin is free only in 3-wire transmit-only use
        ctl_nxt[6] = !mode_r[SCMC_M_MODE_HI] && transmit_only;
        ctl_nxt[7] = 1'b0;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_r <= 8'h00;
        end else begin
            ctl_r <= ctl_nxt;
        end
    end

    assign mem_rdata = rdata_r;
    assign channel_enable = ctl_r[0];
    assign three_wire_mode = ctl_r[1];
    assign two_wire_mode = ctl_r[2];
    assign i2c_mode = ctl_r[3];
    assign pin_or_order_select = ctl_r[4];
    assign wakeup_enable = ctl_r[5];
    assign serial_in_released = ctl_r[6];
    assign serial_clk_tick = tick_r;
    assign prescaler_select = presc_r;
    assign open_drain_busy = busctl_r[SCMC_B_BUSY];
    assign ack_auto_enable = busctl_r[SCMC_B_ACKE];
    assign ack_trigger = trig_r[2];
    assign start_trigger = trig_r[1];
    assign release_trigger = trig_r[0];
    assign address_match_flag = match_r;
    assign start_detected_flag = startd_r;
    assign interrupt_req = irq_r;
endmodule // scmc_ctrl
`default_nettype wire

//--- scmc_pkg.sv
// Package: addresses, field positions, reset values and mode codes of the serial channel control
`default_nettype none
package scmc_pkg;
    localparam logic [15:0] SCMC_ADDR_MODE = 16'hFF60;
    localparam logic [15:0] SCMC_ADDR_BUSCTL = 16'hFF61;
    localparam logic [15:0] SCMC_ADDR_PRESC = 16'hFF43;
    localparam logic [7:0] SCMC_RST_MODE = 8'h00;
    localparam logic [7:0] SCMC_RST_BUSCTL = 8'h00;
    localparam logic [7:0] SCMC_RST_PRESC = 8'h88;
    // Mode register fields
    localparam int SCMC_M_EN = 7;
    localparam int SCMC_M_MATCH = 6;
    localparam int SCMC_M_WAKE = 5;
    localparam int SCMC_M_MODE_HI = 4;
    localparam int SCMC_M_MODE_MID = 3;
    localparam int SCMC_M_PIN = 2;
    localparam int SCMC_M_CLK_HI = 1;
    localparam int SCMC_M_CLK_LO = 0;
    // Bus interface control fields
    localparam int SCMC_B_BUSY = 7;
    localparam int SCMC_B_ACKD = 6;
    localparam int SCMC_B_ACKE = 5;
    localparam int SCMC_B_ACKT = 4;
    localparam int SCMC_B_START = 3;
    localparam int SCMC_B_STOPD = 2;
    localparam int SCMC_B_CMDT = 1;
    localparam int SCMC_B_RELT = 0;
    // Writable bits; the rest are hardware flags or self-clearing triggers
    localparam logic [7:0] SCMC_MODE_WMASK = 8'hBF;
    localparam logic [7:0] SCMC_BUSCTL_WMASK = 8'hA0;
    // Clock source codes on the two clock select bits, the two-wire mode code and the I2C timer divide
    localparam logic [1:0] SCMC_CLK_TIMER = 2'h2;
    localparam logic [1:0] SCMC_CLK_PRESC = 2'h3;
    localparam logic [1:0] SCMC_MODE_TWO_WIRE = 2'h3;
    localparam int SCMC_I2C_TIMER_DIV = 16;
    typedef enum logic [1:0] {
        SCMC_SRC_EXT,
        SCMC_SRC_TIMER,
        SCMC_SRC_PRESC
    } scmc_src_t;
endpackage
`default_nettype wire

//--- scmc_pulse_div.sv
// Pulse divider: one output pulse for every DIV input pulses
`timescale 1ns/1ps
`default_nettype none
module scmc_pulse_div #(
    parameter int DIV = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clr,
    input wire logic pulse_in,
    output logic pulse_out
);
    localparam int CW = $clog2(DIV);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic out_r, out_nxt;

    // Count input pulses, restart when the source changes
    always_comb begin
        cnt_nxt = cnt_r;
        out_nxt = 1'b0;
        if (clr) begin
            cnt_nxt = '0;
        end else if (pulse_in) begin
            if (cnt_r == LAST) begin
                cnt_nxt = '0;
                out_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
            out_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            out_r <= out_nxt;
        end
    end

    assign pulse_out = out_r;
endmodule // scmc_pulse_div
`default_nettype wire

//--- scmc_ctrl_props.sv
// Checker of the mode, flag and interrupt behaviour of the serial channel control
`timescale 1ns/1ps
`default_nettype none
module scmc_ctrl_props
    import scmc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [15:0] mem_addr,
    input wire logic mem_byte_wr,
    input wire logic [7:0] mem_wdata,
    input wire logic [7:0] shift_register,
    input wire logic [7:0] slave_addr,
    input wire logic transfer_done,
    input wire logic start_cond_det,
    input wire logic stop_cond_det,
    input wire logic addr_received,
    input wire logic channel_enable,
    input wire logic three_wire_mode,
    input wire logic two_wire_mode,
    input wire logic i2c_mode,
    input wire logic wakeup_enable,
    input wire logic ack_trigger,
    input wire logic address_match_flag,
    input wire logic start_detected_flag,
    input wire logic interrupt_req
);
    // One domain, so clock and reset are shared by every property
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_en;
        logic v;
        (mem_byte_wr && mem_addr == SCMC_ADDR_MODE, v = mem_wdata[SCMC_M_EN]) |-> ##2 channel_enable == v;
    endproperty
    a_en: assert property (p_en) else $error("enable output misses mode write");
    // Flag follows the compare of the previous cycle, gated by enable
    property p_match;
        address_match_flag == (channel_enable && $past(slave_addr) == $past(shift_register));
    endproperty
    a_match: assert property (p_match) else $error("match flag wrong");
    property p_irq_done;
        transfer_done && channel_enable && !wakeup_enable |=> interrupt_req;
    endproperty
    a_irq_done: assert property (p_irq_done) else $error("no irq after transfer");
    property p_irq_en;
        interrupt_req |-> channel_enable;
    endproperty
    a_irq_en: assert property (p_irq_en) else $error("irq while stopped");
    property p_wake;
        interrupt_req && wakeup_enable |-> i2c_mode && $past(addr_received)
            && $past(start_detected_flag) && $past(address_match_flag);
    endproperty
    a_wake: assert property (p_wake) else $error("wake irq without cause");
    property p_start;
        start_cond_det && channel_enable |=> start_detected_flag;
    endproperty
    a_start: assert property (p_start) else $error("start flag not set");
    property p_stop;
        stop_cond_det && !start_cond_det |=> !start_detected_flag;
    endproperty
    a_stop: assert property (p_stop) else $error("start flag not cleared");
    property p_modes;
        $onehot0({three_wire_mode, two_wire_mode, i2c_mode});
    endproperty
    a_modes: assert property (p_modes) else $error("two modes at once");
    property p_trig;
        ack_trigger |=> !ack_trigger;
    endproperty
    a_trig: assert property (p_trig) else $error("trigger longer than a pulse");
endmodule // scmc_ctrl_props
`default_nettype wire

//--- serial_channel_mode_control_bench.sv
// Self-checking bench of the serial channel mode, flag and clock control
`timescale 1ns/1ps
`default_nettype none
module serial_channel_mode_control_bench;
    import scmc_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, mem_byte_wr = 1'b0, mem_bit_wr = 1'b0, mem_rd = 1'b0;
    logic mem_bit_val = 1'b0, i2c_protocol = 1'b0, transmit_only = 1'b0;
    logic [15:0] mem_addr = 16'h0000;
    logic [2:0] mem_bit_idx = 3'h0;
    logic [2:0] src = 3'h0;
    logic [5:0] ev = 6'h00;
    logic [7:0] mem_wdata = 8'h00, shift_register = 8'h00, slave_addr = 8'h01, mem_rdata, w;
    logic [7:0] prescaler_select;
    logic transfer_start, transfer_done, start_cond_det, stop_cond_det, addr_received, ack_det;
    logic serial_clock_pin, timer_two_output, prescaler_tick, channel_enable, three_wire_mode;
    logic two_wire_mode, i2c_mode, pin_or_order_select, wakeup_enable, serial_in_released;
    logic serial_clk_tick, open_drain_busy, ack_auto_enable, ack_trigger, start_trigger;
    logic release_trigger, address_match_flag, start_detected_flag, interrupt_req;
    int err_total = 0, samples_checked = 0, ticks = 0, cyc = 0, n, i;
    int seed = 32'h627b_a388;
    // Event pulses and clock sources driven as small vectors
    assign {ack_det, addr_received, stop_cond_det, start_cond_det, transfer_done, transfer_start} = ev;
    assign {prescaler_tick, timer_two_output, serial_clock_pin} = src;
    always #2 clk = ~clk;
    scmc_ctrl i_scmc_ctrl (.clk, .rst_n, .mem_addr, .mem_byte_wr, .mem_bit_wr, .mem_bit_idx,
        .mem_bit_val, .mem_wdata, .mem_rd, .mem_rdata, .shift_register, .slave_addr,
        .i2c_protocol, .transmit_only, .transfer_start, .transfer_done, .start_cond_det,
        .stop_cond_det, .addr_received, .ack_det, .serial_clock_pin, .timer_two_output,
        .prescaler_tick, .channel_enable, .three_wire_mode, .two_wire_mode, .i2c_mode,
        .pin_or_order_select, .wakeup_enable, .serial_in_released, .serial_clk_tick,
        .prescaler_select, .open_drain_busy, .ack_auto_enable, .ack_trigger, .start_trigger,
        .release_trigger, .address_match_flag, .start_detected_flag, .interrupt_req);
    // Tick counter and hang guard; the guard at twenty thousand cycles bounds a run of a few hundred cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (serial_clk_tick === 1'b1) ticks <= ticks + 1;
        if (cyc == 20000) begin
            err_total++;
            results();
        end
    end
    function automatic logic [7:0] mode_exp(input logic [7:0] v, input logic m);
        return {v[7], m, v[5:0]};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        mem_addr = a;
        mem_wdata = d;
        mem_byte_wr = 1'b1;
        @(negedge clk);
        mem_byte_wr = 1'b0;
    endtask
    task automatic bwr(input logic [15:0] a, input logic [2:0] b, input logic v);
        @(negedge clk);
        mem_addr = a;
        mem_bit_idx = b;
        mem_bit_val = v;
        mem_bit_wr = 1'b1;
        @(negedge clk);
        mem_bit_wr = 1'b0;
    endtask
    task automatic rdchk(input logic [15:0] a, input logic [7:0] exp);
        @(negedge clk);
        mem_addr = a;
        mem_rd = 1'b1;
        @(negedge clk);
        mem_rd = 1'b0;
        chk(mem_rdata, exp);
    endtask
    // Pulse ends at the next falling edge, where registered answers are already visible
    task automatic pulse(input logic [5:0] m);
        @(negedge clk);
        ev = m;
        @(negedge clk);
        ev = 6'h00;
    endtask
    task automatic run_clk(input logic [2:0] k, input int cnt, input int exp);
        ticks = 0;
        repeat (cnt) begin
            @(negedge clk);
            src = k;
            @(negedge clk);
            src = 3'h0;
        end
        repeat (4) @(negedge clk);
        chk(ticks[7:0], exp[7:0]);
    endtask
    task automatic results;
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        chk(prescaler_select, 8'h88);
        rdchk(SCMC_ADDR_MODE, 8'h00);
        rdchk(SCMC_ADDR_BUSCTL, 8'h00);
        rdchk(16'h1234, 8'h00);
        // Random mode bytes, always from a stopped channel, compare kept unequal
        for (i = 0; i < 8; i++) begin
            w = $random(seed);
            i2c_protocol = w[0];
            shift_register = w;
            slave_addr = ~w;
            wr(SCMC_ADDR_MODE, 8'h00);
            wr(SCMC_ADDR_MODE, w);
            rdchk(SCMC_ADDR_MODE, mode_exp(w, 1'b0));
            chk(channel_enable, w[7]);
            chk(pin_or_order_select, w[2]);
        end
        wr(SCMC_ADDR_MODE, 8'h00);
        bwr(SCMC_ADDR_MODE, 3'h7, 1'b1);
        bwr(SCMC_ADDR_MODE, 3'h6, 1'b1);
        rdchk(SCMC_ADDR_MODE, 8'h80);
        slave_addr = shift_register;
        repeat (2) @(negedge clk);
        chk(address_match_flag, 1'b1);
        rdchk(SCMC_ADDR_MODE, 8'hC0);
        bwr(SCMC_ADDR_MODE, 3'h7, 1'b0);
        // Flag drops one cycle after the enable bit clears
        @(negedge clk);
        chk(address_match_flag, 1'b0);
        wr(SCMC_ADDR_BUSCTL, 8'hFF);
        rdchk(SCMC_ADDR_BUSCTL, 8'hA0);
        chk(open_drain_busy, 1'b1);
        wr(SCMC_ADDR_BUSCTL, 8'h00);
        // Mode decode, with transmit-only use releasing the input pin in 3-wire
        transmit_only = 1'b1;
        for (i = 0; i < 3; i++) begin
            i2c_protocol = (i == 2);
            wr(SCMC_ADDR_MODE, 8'h00);
            wr(SCMC_ADDR_MODE, (i == 0) ? 8'h80 : 8'h98);
            @(negedge clk);
            chk({serial_in_released, three_wire_mode, two_wire_mode, i2c_mode},
                (i == 0) ? 8'h0C : ((i == 1) ? 8'h02 : 8'h01));
        end
        wr(SCMC_ADDR_MODE, 8'h00);
        wr(SCMC_ADDR_MODE, 8'h80);
        pulse(6'h02);
        chk(interrupt_req, 1'b1);
        // Triggers pulse once while enabled and read back as zero; bit write sets busy
        wr(SCMC_ADDR_BUSCTL, 8'h33);
        chk({ack_auto_enable, ack_trigger, start_trigger, release_trigger}, 8'h0F);
        @(negedge clk);
        chk({ack_auto_enable, ack_trigger, start_trigger, release_trigger}, 8'h08);
        rdchk(SCMC_ADDR_BUSCTL, 8'h20);
        bwr(SCMC_ADDR_BUSCTL, 3'h7, 1'b1);
        chk(open_drain_busy, 1'b1);
        wr(SCMC_ADDR_BUSCTL, 8'h00);
        // Wake-up in I2C: only a matching address after a start interrupts
        wr(SCMC_ADDR_MODE, 8'h00);
        i2c_protocol = 1'b1;
        wr(SCMC_ADDR_MODE, 8'hB8);
        pulse(6'h04);
        chk(start_detected_flag, 1'b1);
        chk(wakeup_enable, 1'b1);
        pulse(6'h10);
        chk(interrupt_req, 1'b1);
        slave_addr = ~shift_register;
        repeat (2) @(negedge clk);
        pulse(6'h10);
        chk(interrupt_req, 1'b0);
        pulse(6'h02);
        chk(interrupt_req, 1'b0);
        pulse(6'h08);
        chk(start_detected_flag, 1'b0);
        // Start flag also clears on a transfer start and on channel disable
        pulse(6'h04);
        pulse(6'h01);
        chk(start_detected_flag, 1'b0);
        pulse(6'h04);
        wr(SCMC_ADDR_MODE, 8'h00);
        @(negedge clk);
        chk(start_detected_flag, 1'b0);
        // Prescaler loaded by a byte write, here with the channel stopped
        wr(SCMC_ADDR_PRESC, 8'h8B);
        rdchk(SCMC_ADDR_PRESC, 8'h8B);
        chk(prescaler_select, 8'h8B);
        // Clock sources: pin, timer, prescaler, then timer divided in I2C
        for (i = 0; i < 3; i++) begin
            i2c_protocol = 1'b0;
            n = ($random(seed) & 7) + 1;
            wr(SCMC_ADDR_MODE, 8'h00);
            wr(SCMC_ADDR_MODE, 8'h81 + i[7:0]);
            run_clk(3'h1 << i, n, n);
        end
        wr(SCMC_ADDR_MODE, 8'h00);
        i2c_protocol = 1'b1;
        wr(SCMC_ADDR_MODE, 8'h9A);
        run_clk(3'h2, 32, 32 / SCMC_I2C_TIMER_DIV);
        results();
    end
endmodule // serial_channel_mode_control_bench
bind scmc_ctrl scmc_ctrl_props i_scmc_ctrl_props (.clk, .rst_n, .mem_addr, .mem_byte_wr,
    .mem_wdata, .shift_register, .slave_addr, .transfer_done, .start_cond_det, .stop_cond_det,
    .addr_received, .channel_enable, .three_wire_mode, .two_wire_mode, .i2c_mode,
    .wakeup_enable, .ack_trigger, .address_match_flag, .start_detected_flag, .interrupt_req);
`default_nettype wire
